// >>> hw/iet_pkg.sv
/*
  Package of the interrupt and event transfer controller: register map,
  field positions, timing figures, state encoding and carrier structs.
  Assumes a 32-bit APB slave port and a CPU core on the service side.
*/
package iet_pkg;

  localparam int NSRC = 16;
  localparam int NCHN = 8;
  localparam int SRC_W = 4;
  localparam int CHN_W = 3;
  localparam int PRIO_W = 4;
  localparam int TRAP_W = 7;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 8;
  localparam int VEC_W = 16;

  // Register map, byte addresses
  localparam logic [3:0]  REGION_SRC  = 4'h0;
  localparam logic [3:0]  REGION_CHN  = 4'h1;
  localparam logic [11:0] ADDR_STAT   = 12'h200;
  localparam logic [11:0] ADDR_MASK   = 12'h204;
  localparam logic [11:0] ADDR_STATE  = 12'h208;
  localparam logic [1:0]  CHN_WORD_CTL = 2'h0;
  localparam logic [1:0]  CHN_WORD_SRC = 2'h1;
  localparam logic [1:0]  CHN_WORD_DST = 2'h2;

  // Source control register fields
  localparam int SC_PRIO_LSB = 0;
  localparam int SC_EN_BIT   = 6;
  localparam int SC_REQ_BIT  = 7;
  localparam int SC_XFER_BIT = 8;
  localparam int SC_CHN_LSB  = 9;

  // Channel control register fields
  localparam int CC_CNT_LSB  = 0;
  localparam int CC_CONT_BIT = 8;
  localparam int CC_WORD_BIT = 9;
  localparam int CC_DST_BIT  = 10;

  // Status and mask bits
  localparam int ST_XFER_BIT = 0;
  localparam int ST_ZERO_BIT = 1;
  localparam int ST_ACK_BIT  = 2;
  localparam int ST_W        = 3;

  // Vectors: trap number times four
  localparam logic [TRAP_W-1:0] SRC_TRAP_BASE = 7'h10;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;

  // Response time
  localparam int CLK_MHZ    = 100;
  localparam int LAT_MIN_NS = 125;
  localparam int LAT_MAX_NS = 300;
  localparam int LAT_MIN_CYC = (LAT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_MAX_CYC = (LAT_MAX_NS * CLK_MHZ) / 1000;
  localparam int LAT_W = 5;
  localparam logic [LAT_W-1:0] LAT_WAIT = LAT_W'(LAT_MIN_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_PRES = 2'b11,
    ST_XFER = 2'b10
  } iet_state_e;

  typedef struct packed {
    logic              xfer;
    logic [CHN_W-1:0]  chan;
    logic              req;
    logic              en;
    logic [PRIO_W-1:0] prio;
  } iet_src_s;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CNT_W-1:0]  cnt;
    logic              cont;
    logic              word;
    logic              inc_dst;
  } iet_chn_s;

  typedef struct packed {
    logic              req;
    logic [VEC_W-1:0]  vec;
    logic [PRIO_W-1:0] lvl;
  } iet_irq_s;

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic              word;
  } iet_xfer_s;

endpackage

// >>> hw/iet_prio_sel.sv
/*
  Priority selector: picks the highest priority among candidate sources.
  Assumes candidates are already filtered by enable and level; on equal
  priority the lowest source index wins.
*/
`timescale 1ns/100ps
`default_nettype none

module iet_prio_sel (
  input  wire logic [iet_pkg::NSRC-1:0]                     cand,
  input  wire logic [iet_pkg::NSRC-1:0][iet_pkg::PRIO_W-1:0] prio,
  output logic                                              valid,
  output logic [iet_pkg::SRC_W-1:0]                         idx,
  output logic [iet_pkg::PRIO_W-1:0]                        lvl
);

  always_comb begin
    valid = 1'b0;
    idx   = '0;
    lvl   = '0;
    for (int i = iet_pkg::NSRC - 1; i >= 0; i--) begin
      if (cand[i] && (!valid || prio[i] >= lvl)) begin
        valid = 1'b1;
        idx   = iet_pkg::SRC_W'(i);
        lvl   = prio[i];
      end
    end
  end

endmodule // iet_prio_sel

`default_nettype wire

// >>> hw/iet_ctrl.sv
/*
  Interrupt and event transfer controller: per-source control registers,
  priority arbitration against the CPU level, vectored interrupts, trap
  vectors and eight one-cycle event transfer channels, APB register port.
  Assumes the CPU performs a requested transfer in the cycle it is shown,
  reports its running level on cpu_ilvl and pulses cpu_ack on service start.
*/
// Behaviour
// - Each request is served as an interrupt or as an event transfer.
// - An event transfer steals one cycle; no program suspension or vector.
// - A transfer moves byte or word, then bumps source or destination pointer.
// - Transfer counter decrements per service unless continuous mode is set.
// - Counter at zero turns the request into a standard vectored interrupt.
// - Eight independent channels, each with pointers and a counter.
// - Each source has a control register: request, enable, priority.
// - Priority field selects one of sixteen levels.
// - Running service is preempted only by strictly higher priority.
// - Standard interrupts branch to a vector dedicated to each source.
// - Trap instruction with a trap number selects the matching vector.
// - Request to service latency 125ns to 300ns; event transfers here start two cycles (20ns) after src_req.
`timescale 1ns/100ps
`default_nettype none

module iet_ctrl (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [iet_pkg::NSRC-1:0]      src_req,
  input  wire logic [iet_pkg::PRIO_W-1:0]    cpu_ilvl,
  input  wire logic                          cpu_ack,
  input  wire logic                          trap_valid,
  input  wire logic [iet_pkg::TRAP_W-1:0]    trap_num,
  output iet_pkg::iet_irq_s                  irq,
  output iet_pkg::iet_xfer_s                 xfer,
  output logic                               int_out
);

  iet_pkg::iet_src_s [iet_pkg::NSRC-1:0]  src_reg;
  iet_pkg::iet_src_s [iet_pkg::NSRC-1:0]  src_next;
  iet_pkg::iet_chn_s [iet_pkg::NCHN-1:0]  chn_reg;
  iet_pkg::iet_chn_s [iet_pkg::NCHN-1:0]  chn_next;
  iet_pkg::iet_state_e                    state_reg;
  iet_pkg::iet_state_e                    state_next;
  iet_pkg::iet_irq_s                      irq_reg;
  iet_pkg::iet_xfer_s                     xfer_reg;
  logic [iet_pkg::SRC_W-1:0]              cur_reg;
  logic                                   trap_sel_reg;
  logic                                   trap_pend_reg;
  logic [iet_pkg::TRAP_W-1:0]             trap_no_reg;
  logic [iet_pkg::LAT_W-1:0]              lat_reg;
  logic [iet_pkg::ST_W-1:0]               stat_reg;
  logic [iet_pkg::ST_W-1:0]               mask_reg;
  logic [iet_pkg::ST_W-1:0]               stat_next;
  logic [31:0]                            prdata_reg;
  logic                                   pready_reg;
  logic                                   pslverr_reg;
  logic                                   int_reg;

  // APB decode
  wire logic       setup    = psel && !penable;
  wire logic       acc      = psel && penable && pready_reg;
  wire logic       wr       = acc && pwrite;
  wire logic [3:0] region   = paddr[11:8];
  wire logic       hit_src  = (region == iet_pkg::REGION_SRC) && (paddr[7:6] == 2'b00);
  wire logic       hit_chn  = (region == iet_pkg::REGION_CHN) && !paddr[7]
                              && (paddr[3:2] != 2'b11);
  wire logic       hit_stat = (paddr == iet_pkg::ADDR_STAT);
  wire logic       hit_mask = (paddr == iet_pkg::ADDR_MASK);
  wire logic       hit_st   = (paddr == iet_pkg::ADDR_STATE);
  wire logic       hit      = hit_src || hit_chn || hit_stat || hit_mask || hit_st;
  wire logic [iet_pkg::SRC_W-1:0] a_src = paddr[5:2];
  wire logic [iet_pkg::CHN_W-1:0] a_chn = paddr[6:4];
  wire logic [1:0]                a_wrd = paddr[3:2];
  wire logic       rd_stat  = acc && !pwrite && hit_stat;

  // Arbitration inputs
  logic [iet_pkg::NSRC-1:0]                      cand;
  logic [iet_pkg::NSRC-1:0][iet_pkg::PRIO_W-1:0] prio_v;
  logic                                          win_valid;
  logic [iet_pkg::SRC_W-1:0]                     win_idx;
  logic [iet_pkg::PRIO_W-1:0]                    win_lvl;

  iet_prio_sel u_sel (
    .cand  (cand),
    .prio  (prio_v),
    .valid (win_valid),
    .idx   (win_idx),
    .lvl   (win_lvl)
  );

  wire iet_pkg::iet_src_s win_src = src_reg[win_idx];
  wire iet_pkg::iet_chn_s win_chn = chn_reg[win_src.chan];
  wire logic win_xfer = win_src.xfer && (win_chn.cont || (win_chn.cnt != '0));
  wire iet_pkg::iet_src_s cur_src = src_reg[cur_reg];
  wire logic cur_live = cur_src.req && cur_src.en && (cur_src.prio > cpu_ilvl);
  wire logic xfer_done = (state_reg == iet_pkg::ST_XFER);
  wire logic svc_ack   = (state_reg == iet_pkg::ST_PRES) && cpu_ack;
  wire iet_pkg::iet_chn_s cur_chn = chn_reg[cur_src.chan];
  wire logic zero_hit  = xfer_done && !cur_chn.cont && (cur_chn.cnt == iet_pkg::CNT_W'(1));

  // Per-source control registers
  for (genvar g = 0; g < iet_pkg::NSRC; g++) begin : g_src
    wire logic wr_this = wr && hit_src && (a_src == iet_pkg::SRC_W'(g));
    wire logic clr     = (xfer_done || (svc_ack && !trap_sel_reg))
                         && (cur_reg == iet_pkg::SRC_W'(g));
    assign cand[g]   = src_reg[g].req && src_reg[g].en && (src_reg[g].prio > cpu_ilvl);
    assign prio_v[g] = src_reg[g].prio;
    always_comb begin
      src_next[g] = src_reg[g];
      if (wr_this) begin
        src_next[g].prio = pwdata[iet_pkg::SC_PRIO_LSB +: iet_pkg::PRIO_W];
        src_next[g].en   = pwdata[iet_pkg::SC_EN_BIT];
        src_next[g].req  = pwdata[iet_pkg::SC_REQ_BIT];
        src_next[g].xfer = pwdata[iet_pkg::SC_XFER_BIT];
        src_next[g].chan = pwdata[iet_pkg::SC_CHN_LSB +: iet_pkg::CHN_W];
      end else if (clr) begin
        src_next[g].req = 1'b0;
      end
      if (src_req[g]) begin
        src_next[g].req = 1'b1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_reg[g] <= '0;
      end else begin
        src_reg[g] <= src_next[g];
      end
    end
  end

  // Per-channel pointers and counters
  for (genvar c = 0; c < iet_pkg::NCHN; c++) begin : g_chn
    wire logic wr_c = wr && hit_chn && (a_chn == iet_pkg::CHN_W'(c));
    wire logic upd  = xfer_done && (cur_src.chan == iet_pkg::CHN_W'(c));
    wire logic [iet_pkg::ADDR_W-1:0] step = chn_reg[c].word ? iet_pkg::STEP_WORD
                                                           : iet_pkg::STEP_BYTE;
    always_comb begin
      chn_next[c] = chn_reg[c];
      if (wr_c && (a_wrd == iet_pkg::CHN_WORD_CTL)) begin
        chn_next[c].cnt     = pwdata[iet_pkg::CC_CNT_LSB +: iet_pkg::CNT_W];
        chn_next[c].cont    = pwdata[iet_pkg::CC_CONT_BIT];
        chn_next[c].word    = pwdata[iet_pkg::CC_WORD_BIT];
        chn_next[c].inc_dst = pwdata[iet_pkg::CC_DST_BIT];
      end else if (wr_c && (a_wrd == iet_pkg::CHN_WORD_SRC)) begin
        chn_next[c].src = pwdata[iet_pkg::ADDR_W-1:0];
      end else if (wr_c && (a_wrd == iet_pkg::CHN_WORD_DST)) begin
        chn_next[c].dst = pwdata[iet_pkg::ADDR_W-1:0];
      end else if (upd) begin
        if (chn_reg[c].inc_dst) begin
          chn_next[c].dst = chn_reg[c].dst + step;
        end else begin
          chn_next[c].src = chn_reg[c].src + step;
        end
        if (!chn_reg[c].cont) begin
          chn_next[c].cnt = chn_reg[c].cnt - iet_pkg::CNT_W'(1);
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chn_reg[c] <= '0;
      end else begin
        chn_reg[c] <= chn_next[c];
      end
    end
  end

  // Service sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      iet_pkg::ST_IDLE: begin
        if (trap_pend_reg) begin
          state_next = iet_pkg::ST_PRES;
        end else if (win_valid && win_xfer) begin
          state_next = iet_pkg::ST_XFER;
        end else if (win_valid) begin
          state_next = iet_pkg::ST_WAIT;
        end
      end
      iet_pkg::ST_WAIT: begin
        if (!cur_live) begin
          state_next = iet_pkg::ST_IDLE;
        end else if (lat_reg == iet_pkg::LAT_WAIT) begin
          state_next = iet_pkg::ST_PRES;
        end
      end
      iet_pkg::ST_PRES: begin
        if (cpu_ack) begin
          state_next = iet_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = iet_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic [iet_pkg::TRAP_W-1:0] src_trap = iet_pkg::SRC_TRAP_BASE
                                              + iet_pkg::TRAP_W'(cur_reg);
  wire logic enter_idle_pick = (state_reg == iet_pkg::ST_IDLE) && !trap_pend_reg && win_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= iet_pkg::ST_IDLE;
      cur_reg       <= '0;
      trap_sel_reg  <= 1'b0;
      trap_pend_reg <= 1'b0;
      trap_no_reg   <= '0;
      lat_reg       <= '0;
      irq_reg       <= '0;
      xfer_reg      <= '0;
    end else begin
      state_reg <= state_next;
      if (trap_valid) begin
        trap_pend_reg <= 1'b1;
        trap_no_reg   <= trap_num;
      end else if ((state_reg == iet_pkg::ST_IDLE) && trap_pend_reg) begin
        trap_pend_reg <= 1'b0;
      end
      if (enter_idle_pick) begin
        cur_reg <= win_idx;
      end
      if ((state_reg == iet_pkg::ST_IDLE) && trap_pend_reg) begin
        trap_sel_reg <= 1'b1;
        irq_reg.req  <= 1'b1;
        irq_reg.vec  <= {7'h00, trap_no_reg, 2'b00};
        irq_reg.lvl  <= cpu_ilvl;
      end else if ((state_reg == iet_pkg::ST_WAIT) && (state_next == iet_pkg::ST_PRES)) begin
        trap_sel_reg <= 1'b0;
        irq_reg.req  <= 1'b1;
        irq_reg.vec  <= {7'h00, src_trap, 2'b00};
        irq_reg.lvl  <= cur_src.prio;
      end else if (svc_ack) begin
        irq_reg.req <= 1'b0;
      end
      lat_reg <= (state_reg == iet_pkg::ST_WAIT) ? lat_reg + iet_pkg::LAT_W'(1) : '0;
      if (enter_idle_pick && win_xfer) begin
        xfer_reg.req  <= 1'b1;
        xfer_reg.src  <= win_chn.src;
        xfer_reg.dst  <= win_chn.dst;
        xfer_reg.word <= win_chn.word;
      end else begin
        xfer_reg.req <= 1'b0;
      end
    end
  end

  // Sticky events; a read clears only the bits it returned, a new event wins
  wire logic [iet_pkg::ST_W-1:0] ev = {svc_ack, zero_hit, xfer_done};
  assign stat_next = ev | (stat_reg & ~(rd_stat ? prdata_reg[iet_pkg::ST_W-1:0] : '0));

  // Read-back places each field where the write decode takes it
  wire iet_pkg::iet_src_s rs = src_reg[a_src];
  wire logic [31:0] rd_src_w = {20'h0_0000, rs.chan, rs.xfer, rs.req, rs.en, 2'b00,
                                rs.prio};
  wire iet_pkg::iet_chn_s rc = chn_reg[a_chn];
  wire logic [31:0] rd_ctl_w = {21'h00_0000, rc.inc_dst, rc.word, rc.cont, rc.cnt};
  wire logic [31:0] rd_chn_w = (a_wrd == iet_pkg::CHN_WORD_CTL) ? rd_ctl_w :
                               (a_wrd == iet_pkg::CHN_WORD_SRC) ? {16'h0000, rc.src} :
                                                                  {16'h0000, rc.dst};
  wire logic [31:0] rd_st_w  = {23'h00_0000, trap_sel_reg, cur_reg, 2'b00,
                                state_reg};
  logic [31:0] rd_data;
  always_comb begin
    if (hit_src) begin
      rd_data = rd_src_w;
    end else if (hit_chn) begin
      rd_data = rd_chn_w;
    end else if (hit_stat) begin
      rd_data = {29'h0000_0000, stat_reg};
    end else if (hit_mask) begin
      rd_data = {29'h0000_0000, mask_reg};
    end else if (hit_st) begin
      rd_data = rd_st_w;
    end else begin
      rd_data = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg    <= '0;
      mask_reg    <= '0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      int_reg     <= 1'b0;
    end else begin
      stat_reg    <= stat_next;
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit;
      prdata_reg  <= (setup && !pwrite) ? rd_data : '0;
      int_reg     <= |(stat_next & mask_reg);
      if (wr && hit_mask) begin
        mask_reg <= pwdata[iet_pkg::ST_W-1:0];
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;
  assign xfer    = xfer_reg;
  assign int_out = int_reg;

endmodule // iet_ctrl

`default_nettype wire

// >>> verification/iet_ctrl_checker.sv
/*
  Port checker of iet_ctrl: APB answer, transfer pulses, vector hand-over.
  Assumes it is bound to each iet_ctrl and reads its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module iet_ctrl_checker (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic                         cpu_ack,
  input wire logic [iet_pkg::PRIO_W-1:0]   cpu_ilvl,
  input wire iet_pkg::iet_irq_s            irq,
  input wire iet_pkg::iet_xfer_s           xfer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges seen with no vector presented since the last one
  logic [4:0] low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
    end else if (irq.req) begin
      low_cnt <= '0;
    end else if (low_cnt != 5'h1F) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  a_xfer_single: assert property (xfer.req |=> !xfer.req)
    else $error("transfer pulse too long");
  a_xfer_no_vec: assert property (xfer.req |-> !irq.req)
    else $error("vector during transfer");
  a_irq_holds: assert property (irq.req && !cpu_ack |=> irq.req && $stable(irq.vec))
    else $error("vector not held");
  a_ack_clears: assert property (irq.req && cpu_ack |=> !irq.req)
    else $error("vector kept after ack");
  a_vec_word: assert property (irq.req |-> irq.vec[1:0] == 2'b00)
    else $error("vector not word aligned");
  a_lvl_above: assert property ($rose(irq.req) && irq.vec >= 16'h0040
    && irq.vec < 16'h0080 |-> irq.lvl > $past(cpu_ilvl))
    else $error("level not above running level");
  a_wait_min: assert property ($rose(irq.req) && irq.vec >= 16'h0040
    && irq.vec < 16'h0080 |-> low_cnt > 5'(iet_pkg::LAT_MIN_CYC))
    else $error("vector came too soon");
endmodule // iet_ctrl_checker
bind iet_ctrl iet_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .cpu_ack(cpu_ack), .cpu_ilvl(cpu_ilvl),
  .irq(irq), .xfer(xfer));
`default_nettype wire

// >>> verification/iet_cpu_model.sv
/*
  CPU core model: acks a presented vector ack_dly + 1 cycles after it appears, runs at its
  level and restores the previous one on isr_done. Assumes one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module iet_cpu_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire iet_pkg::iet_irq_s irq,
  input  wire logic [3:0]        ack_dly,
  input  wire logic              isr_done,
  output logic                   cpu_ack,
  output logic [3:0]             cpu_ilvl
);
  logic [3:0] wait_cnt;
  logic [3:0] lvl_stk [4];
  logic [1:0] sp;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_ilvl <= '0;
      wait_cnt <= '0;
      sp <= '0;
    end else begin
      cpu_ack <= 1'b0;
      if (irq.req && !cpu_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= ack_dly) begin
          cpu_ack <= 1'b1;
          wait_cnt <= '0;
          lvl_stk[sp] <= cpu_ilvl;
          sp <= sp + 2'h1;
          cpu_ilvl <= irq.lvl;
        end
      end else if (isr_done) begin
        sp <= sp - 2'h1;
        cpu_ilvl <= lvl_stk[sp - 2'h1];
      end
    end
  end
endmodule // iet_cpu_model
`default_nettype wire

// >>> verification/iet_ctrl_tb.sv
/*
  Self-checking bench of iet_ctrl: APB access, vectors, preemption, traps
  and event transfers. Assumes the CPU model on the service side.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module iet_ctrl_tb;
  typedef struct {int s; int p; bit hit;} iet_row_s;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               cpu_ack, int_out, trap_valid, isr_done, err;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [15:0]        src_req;
  logic [3:0]         cpu_ilvl, ack_dly;
  logic [6:0]         trap_num;
  iet_pkg::iet_irq_s  irq;
  iet_pkg::iet_xfer_s xfer;
  int                 miscompares, num_checks, n;
  iet_row_s           rows [5] = '{'{0, 1, 1}, '{5, 15, 1}, '{15, 8, 1}, '{9, 3, 1}, '{11, 0, 0}};
  iet_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .cpu_ilvl(cpu_ilvl), .cpu_ack(cpu_ack),
    .trap_valid(trap_valid), .trap_num(trap_num), .irq(irq), .xfer(xfer), .int_out(int_out));
  iet_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .ack_dly(ack_dly),
    .isr_done(isr_done), .cpu_ack(cpu_ack), .cpu_ilvl(cpu_ilvl));
  function automatic logic [31:0] sc(input int p, input int x = 0, input int ch = 0);
    return 32'(p) | 32'h0000_0040 | 32'(x << 8) | 32'(ch << 9);
  endfunction
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int s);
    @(posedge pclk);
    src_req <= 16'h0001 << s;
    @(posedge pclk);
    src_req <= '0;
  endtask
  // Counts edges until a vector (sel 0) or a transfer (sel 1); 60 means none
  task automatic wait_req(input bit sel);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (n < 60 && (sel ? xfer.req : irq.req) !== 1'b1);
  endtask
  task automatic pop();
    @(posedge pclk);
    isr_done <= 1'b1;
    @(posedge pclk);
    isr_done <= 1'b0;
  endtask
  task automatic serve(input bit done);
    while (cpu_ack !== 1'b1) @(posedge pclk);
    if (done) pop();
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, trap_valid, isr_done} = '0;
    {paddr, pwdata, src_req, trap_num, ack_dly} = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1, 12'(4 * rows[i].s), sc(rows[i].p));
      pulse(rows[i].s);
      wait_req(0);
      `CHK(n < 60, rows[i].hit)
      if (rows[i].hit) begin
        `CHK(n >= 12 && n <= 29, 1'b1)
        `CHK(irq.vec, 16'h0040 + 16'(4 * rows[i].s))
        `CHK(irq.lvl, 4'(rows[i].p))
        serve(1);
      end
      apb(0, 12'(4 * rows[i].s), 0);
      `CHK(rd, sc(rows[i].p) | (rows[i].hit ? 32'h0000_0000 : 32'h0000_0080))
      apb(1, 12'(4 * rows[i].s), 0);
    end
    // Nested service: equal and lower wait, higher preempts
    ack_dly <= 4'h5;
    apb(1, 12'h008, sc(5));
    apb(1, 12'h00C, sc(5));
    apb(1, 12'h010, sc(4));
    apb(1, 12'h018, sc(7));
    pulse(2);
    wait_req(0);
    serve(0);
    pulse(3);
    pulse(4);
    wait_req(0);
    `CHK(n, 60)
    pulse(6);
    wait_req(0);
    `CHK(irq.vec, 16'h0058)
    serve(1);
    pop();
    wait_req(0);
    `CHK(irq.vec, 16'h004C)
    serve(1);
    wait_req(0);
    `CHK(irq.vec, 16'h0050)
    serve(1);
    // Word channel 3 with count 2, byte channel 0 continuous
    apb(1, 12'h204, 32'h0000_0007);
    apb(0, 12'h200, 0);
    apb(1, 12'h130, 32'h0000_0602);
    apb(1, 12'h134, 32'h0000_1000);
    apb(1, 12'h138, 32'h0000_2000);
    apb(1, 12'h100, 32'h0000_0105);
    apb(1, 12'h104, 32'h0000_3000);
    apb(1, 12'h01C, sc(2, 1, 3));
    apb(1, 12'h004, sc(3, 1, 0));
    for (int k = 0; k < 2; k++) begin
      pulse(7);
      wait_req(1);
      `CHK(n <= 4, 1'b1)
      `CHK({xfer.src, xfer.dst, xfer.word}, {16'h1000, 16'h2000 + 16'(2 * k), 1'b1})
      `CHK(irq.req, 1'b0)
      repeat (3) @(posedge pclk);
      `CHK(int_out, 1'b1)
      apb(0, 12'h200, 0);
      `CHK(rd, 32'(2 * k + 1))
    end
    apb(0, 12'h130, 0);
    `CHK(rd[7:0], 8'h00)
    pulse(7);
    wait_req(0);
    `CHK(irq.vec, 16'h005C)
    serve(1);
    apb(1, 12'h204, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      pulse(1);
      wait_req(1);
      `CHK({xfer.src, xfer.word}, {16'h3000 + 16'(k), 1'b0})
    end
    apb(0, 12'h100, 0);
    `CHK(rd[8:0], 9'h105)
    `CHK(int_out, 1'b0)
    apb(0, 12'h138, 0);
    `CHK(rd, 32'h0000_2004)
    @(posedge pclk);
    trap_valid <= 1'b1;
    trap_num <= 7'h25;
    @(posedge pclk);
    trap_valid <= 1'b0;
    wait_req(0);
    `CHK(irq.vec, 16'h0094)
    serve(1);
    apb(0, 12'h300, 0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(irq.req, 1'b0)
    apb(0, 12'h01C, 0);
    `CHK(rd, 32'h0000_0000)
    wrap_up();
  end
endmodule // iet_ctrl_tb
`default_nettype wire
